// file: rtl/pmic_fault_interrupt_regs.sv
module pmic_fault_interrupt_regs (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // byte register port from the serial host interface
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    // per-output monitoring, bit order switcher a, switcher b, linear a, linear b
    input  wire logic [3:0] output_valid,
    input  wire logic [3:0] monitor_enable,
    input  wire logic       fault_gating_select,
    // per-regulator event registers kept outside
    input  wire logic [7:0] linear_event_register,
    input  wire logic [7:0] switcher_event_register,
    // event sources
    input  wire logic       ext_clock_present,
    input  wire logic       thermal_shutdown_live,
    input  wire logic       thermal_warning_live,
    input  wire logic       input_overvoltage_live,
    input  wire logic       current_result_ready,
    // enable requests from the sequencer
    input  wire logic [3:0] regulator_enable_req,
    input  wire logic       general_output_a_req,
    input  wire logic       general_output_b_req,
    // outputs
    output logic            power_ok_pin,
    output logic [3:0]      regulator_enable,
    output logic            general_output_a,
    output logic            general_output_b,
    output logic            otp_reload,
    output logic            host_if_reset,
    output logic            irq
);

    logic [3:0] fault_q;
    logic [3:0] fault_d;
    logic [7:0] top_q;
    logic [7:0] top_d;
    logic       soft_reset_q;
    logic       power_ok_q;
    logic       power_ok_d;
    logic       ext_clock_prev_q;
    logic [3:0] regulator_enable_q;
    logic       gpo_a_q;
    logic       gpo_b_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic       irq_q;
    logic [7:0] top_value;
    logic [7:0] top_set;
    logic       wr_fault;
    logic       wr_soft_reset;
    logic       wr_top;
    logic       linear_summary;
    logic       switcher_summary;
    logic       trip_outputs;
    logic       history_valid_q;
    logic [3:0] fault_raise;
    logic [3:0] fault_kept;

    // write decode helper
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    // register write strobes
    assign wr_fault      = reg_wr && hit(reg_addr, pmic_fault_pkg::FAULT_LATCH_ADDR);
    assign wr_soft_reset = reg_wr && hit(reg_addr, pmic_fault_pkg::SOFT_RESET_ADDR)
                           && reg_wdata[pmic_fault_pkg::SOFT_RESET_CMD_BIT];
    assign wr_top        = reg_wr && hit(reg_addr, pmic_fault_pkg::TOP_FLAGS_ADDR);

    // summary flags follow the event registers directly
    assign linear_summary   = |linear_event_register;
    assign switcher_summary = |switcher_event_register;

    // protection trip drops regulators and general outputs
    assign trip_outputs = thermal_shutdown_live || input_overvoltage_live
                          || top_q[pmic_fault_pkg::THERMAL_SHUTDOWN_BIT]
                          || top_q[pmic_fault_pkg::INPUT_OVERVOLTAGE_BIT];

    // fault latch next value, set wins over clear
    always_comb begin
        fault_d = fault_q;
        if (wr_fault) begin
            fault_d = fault_q & ~(reg_wdata[3:0] & output_valid);
        end
        fault_d = fault_d | (monitor_enable & ~output_valid);
    end

    // power-ok level, live or from the fault latch
    always_comb begin
        if (fault_gating_select) begin
            power_ok_d = ~|fault_q;
        end else begin
            power_ok_d = &(output_valid | ~monitor_enable);
        end
    end

    // top flag events this cycle
    always_comb begin
        top_set = 8'h00;
        top_set[pmic_fault_pkg::POWER_OK_DROP_BIT]     = power_ok_q && !power_ok_d;
        top_set[pmic_fault_pkg::EXT_CLOCK_BIT]         = history_valid_q && (ext_clock_present ^ ext_clock_prev_q);
        top_set[pmic_fault_pkg::THERMAL_SHUTDOWN_BIT]  = thermal_shutdown_live;
        top_set[pmic_fault_pkg::THERMAL_WARNING_BIT]   = thermal_warning_live;
        top_set[pmic_fault_pkg::INPUT_OVERVOLTAGE_BIT] = input_overvoltage_live;
        top_set[pmic_fault_pkg::CURRENT_RESULT_BIT]    = current_result_ready;
    end

    // top latched flags next value, set wins over clear
    always_comb begin
        top_d = top_q;
        if (wr_top) begin
            top_d = top_q & ~(reg_wdata & pmic_fault_pkg::TOP_LATCHED_MASK);
        end
        top_d = (top_d | top_set) & pmic_fault_pkg::TOP_LATCHED_MASK;
    end

    // value seen by a read of the top register
    always_comb begin
        top_value = top_q;
        top_value[pmic_fault_pkg::LINEAR_SUMMARY_BIT]   = linear_summary;
        top_value[pmic_fault_pkg::SWITCHER_SUMMARY_BIT] = switcher_summary;
    end

    // soft reset command pulse, one cycle, self clearing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_q <= 1'b0;
        end else if (clk_en) begin
            soft_reset_q <= wr_soft_reset && !soft_reset_q;
        end
    end

    // fault latch register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= pmic_fault_pkg::FAULT_LATCH_RESET;
        end else if (clk_en) begin
            if (soft_reset_q) begin
                fault_q <= pmic_fault_pkg::FAULT_LATCH_RESET;
            end else begin
                fault_q <= fault_d;
            end
        end
    end

    // top interrupt flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            top_q <= pmic_fault_pkg::TOP_FLAGS_RESET;
        end else if (clk_en) begin
            if (soft_reset_q) begin
                top_q <= pmic_fault_pkg::TOP_FLAGS_RESET;
            end else begin
                top_q <= top_d;
            end
        end
    end

    // power-ok pin and edge history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_ok_q       <= 1'b0;
            ext_clock_prev_q <= 1'b0;
        end else if (clk_en) begin
            if (soft_reset_q) begin
                power_ok_q       <= 1'b0;
                ext_clock_prev_q <= ext_clock_present;
            end else begin
                power_ok_q       <= power_ok_d;
                ext_clock_prev_q <= ext_clock_present;
            end
        end
    end

    // clock history trusted only after one enabled edge, no false flag out of reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            history_valid_q <= 1'b0;
        end else if (clk_en) begin
            history_valid_q <= 1'b1;
        end
    end

    // regulator enables, refused while shut down or tripped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regulator_enable_q <= pmic_fault_pkg::REG_ENABLE_RESET;
        end else if (clk_en) begin
            if (soft_reset_q || trip_outputs) begin
                regulator_enable_q <= pmic_fault_pkg::REG_ENABLE_RESET;
            end else begin
                regulator_enable_q <= regulator_enable_req;
            end
        end
    end

    // general outputs driven low on protection trip
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpo_a_q <= 1'b0;
            gpo_b_q <= 1'b0;
        end else if (clk_en) begin
            if (soft_reset_q || trip_outputs) begin
                gpo_a_q <= 1'b0;
                gpo_b_q <= 1'b0;
            end else begin
                gpo_a_q <= general_output_a_req;
                gpo_b_q <= general_output_b_req;
            end
        end
    end

    // register read path, unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= pmic_fault_pkg::READ_DATA_RESET;
            rvalid_q <= 1'b0;
        end else if (clk_en) begin
            rvalid_q <= reg_rd && !soft_reset_q;
            if (reg_rd && !soft_reset_q) begin
                unique case (reg_addr)
                    pmic_fault_pkg::FAULT_LATCH_ADDR: rdata_q <= {4'h0, fault_q};
                    pmic_fault_pkg::SOFT_RESET_ADDR:  rdata_q <= 8'h00;
                    pmic_fault_pkg::TOP_FLAGS_ADDR:   rdata_q <= top_value;
                    default:                          rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // interrupt line from any top flag
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |top_value && !soft_reset_q;
        end
    end

    // output ports straight from flops
    assign reg_rdata        = rdata_q;
    assign reg_rvalid       = rvalid_q;
    assign power_ok_pin     = power_ok_q;
    assign regulator_enable = regulator_enable_q;
    assign general_output_a = gpo_a_q;
    assign general_output_b = gpo_b_q;
    assign otp_reload       = soft_reset_q;
    assign host_if_reset    = soft_reset_q;
    assign irq              = irq_q;

    // assertion helpers: bits that must set, bits that no write may clear
    assign fault_raise = monitor_enable & ~output_valid;
    assign fault_kept  = fault_q & ~(output_valid & (wr_fault ? reg_wdata[3:0] : 4'h0));

    // named sequences for the soft reset steps
    sequence soft_reset_write_s;
        clk_en && !soft_reset_q && wr_soft_reset;
    endsequence

    sequence soft_reset_pulse_s;
        soft_reset_q && otp_reload && host_if_reset;
    endsequence

    a_fault_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && |fault_raise)
        |=> ((fault_q & $past(fault_raise)) == $past(fault_raise)))
        else $error("monitored invalid output did not set fault bit");

    a_fault_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q)
        |=> ((fault_q & $past(fault_kept)) == $past(fault_kept)))
        else $error("fault bit cleared without valid write-1");

    a_soft_reset_defaults: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && soft_reset_q) |=> (fault_q == 4'h0 && top_q == 8'h00 && regulator_enable_q == 4'h0))
        else $error("soft reset did not restore defaults");

    a_soft_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        soft_reset_write_s |=> soft_reset_pulse_s ##1 (!soft_reset_q || !$past(clk_en)))
        else $error("soft reset command did not pulse and self clear");

    a_power_drop_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && power_ok_q && !power_ok_d)
        |=> (top_q[pmic_fault_pkg::POWER_OK_DROP_BIT] && !power_ok_pin))
        else $error("power-ok drop not latched");

    a_summary_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && reg_rd && !soft_reset_q && reg_addr == pmic_fault_pkg::TOP_FLAGS_ADDR)
        |=> (reg_rvalid && reg_rdata[6] == ($past(linear_event_register) != 8'h00)
             && reg_rdata[5] == ($past(switcher_event_register) != 8'h00)))
        else $error("summary flags do not follow event registers");

    a_ext_clock_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && history_valid_q && (ext_clock_present != ext_clock_prev_q))
        |=> top_q[pmic_fault_pkg::EXT_CLOCK_BIT])
        else $error("external clock change not latched");

    a_thermal_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && (thermal_shutdown_live || top_q[pmic_fault_pkg::THERMAL_SHUTDOWN_BIT]))
        |=> (regulator_enable == 4'h0 && !general_output_a && !general_output_b))
        else $error("regulator or output active during thermal shutdown");

    a_overvoltage_trip: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && input_overvoltage_live)
        |=> (top_q[pmic_fault_pkg::INPUT_OVERVOLTAGE_BIT] && regulator_enable == 4'h0 && !general_output_a))
        else $error("overvoltage did not trip outputs");

    a_top_clear_w1c: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && wr_top && reg_wdata[0] && !current_result_ready)
        |=> !top_q[pmic_fault_pkg::CURRENT_RESULT_BIT])
        else $error("write-1 did not clear current result flag");

    a_gated_power_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && fault_gating_select && |fault_q) |=> !power_ok_pin)
        else $error("power-ok active while fault latched in gating mode");

    a_irq_tracks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q) |=> (irq == ($past(top_value) != 8'h00)))
        else $error("interrupt output does not track top flags");

    a_reload_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(otp_reload) |-> ($past(wr_soft_reset) && $past(clk_en) && host_if_reset))
        else $error("reload pulse without accepted soft reset write");

    a_warning_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && thermal_warning_live)
        |=> top_q[pmic_fault_pkg::THERMAL_WARNING_BIT])
        else $error("thermal warning not latched");

    a_current_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && current_result_ready)
        |=> top_q[pmic_fault_pkg::CURRENT_RESULT_BIT])
        else $error("current result not latched");

    a_unmonitored_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && !wr_fault)
        |=> ((fault_q & ~$past(monitor_enable)) == ($past(fault_q) & ~$past(monitor_enable))))
        else $error("unmonitored output changed its fault bit");

    a_live_power_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && !fault_gating_select)
        |=> (power_ok_pin == (($past(output_valid) | ~$past(monitor_enable)) == 4'hF)))
        else $error("live power-ok does not follow monitored outputs");

    a_top_write_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !soft_reset_q && wr_top)
        |=> ((top_q & $past(top_q) & ~$past(reg_wdata)) == ($past(top_q) & ~$past(reg_wdata))))
        else $error("top flag lost without write-1");

    a_frozen_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clk_en |=> ($stable(fault_q) && $stable(top_q) && $stable(irq)))
        else $error("state moved while clock enable low");

endmodule : pmic_fault_interrupt_regs

// file: rtl/pmic_fault_pkg.sv
// Summary of operation
// - monitored output going invalid sets its fault latch bit.
// - fault bit clears only on write-1 while that output is valid, or on soft reset.
// - writing 1 to soft reset bit returns all registers to defaults.
// - soft reset also pulses configuration memory reload and serial interface reset.
// - soft reset bit clears itself; reads of it return 0.
// - power-ok pin falling from active to inactive latches bit 7.
// - bit 6 is read-only, set while linear event register is nonzero.
// - bit 5 is read-only, set while switcher event register is nonzero.
// - external clock appearing or disappearing latches bit 4.
// - thermal shutdown latches bit 3, disables regulators, drives both outputs low.
// - no regulator enables while latched thermal shutdown flag is set.
// - thermal warning latches bit 2; live warning is reported elsewhere.
// - input overvoltage latches bit 1, disables regulators, drives outputs low.
// - new load current result latches bit 0.
// - host writes 1 to a latched top flag to clear it.
// - with fault gating selected, power-ok follows the fault latch register.
// - an output feeds power-ok and its fault latch only when monitored.
// - per-regulator event registers feed the two summary flags.
package pmic_fault_pkg;

    // register offsets
    localparam logic [7:0] FAULT_LATCH_ADDR  = 8'h17;
    localparam logic [7:0] SOFT_RESET_ADDR   = 8'h18;
    localparam logic [7:0] TOP_FLAGS_ADDR    = 8'h19;

    // fault latch field positions
    localparam int FAULT_SWITCHER_A_BIT      = 0;
    localparam int FAULT_SWITCHER_B_BIT      = 1;
    localparam int FAULT_LINEAR_A_BIT        = 2;
    localparam int FAULT_LINEAR_B_BIT        = 3;
    localparam int NUM_OUTPUTS               = 4;

    // soft reset command field
    localparam int SOFT_RESET_CMD_BIT        = 0;

    // top interrupt register field positions
    localparam int POWER_OK_DROP_BIT         = 7;
    localparam int LINEAR_SUMMARY_BIT        = 6;
    localparam int SWITCHER_SUMMARY_BIT      = 5;
    localparam int EXT_CLOCK_BIT             = 4;
    localparam int THERMAL_SHUTDOWN_BIT      = 3;
    localparam int THERMAL_WARNING_BIT       = 2;
    localparam int INPUT_OVERVOLTAGE_BIT     = 1;
    localparam int CURRENT_RESULT_BIT        = 0;

    // latched (write-1-to-clear) part of the top register
    localparam logic [7:0] TOP_LATCHED_MASK  = 8'h9F;

    // values after reset
    localparam logic [3:0] FAULT_LATCH_RESET = 4'h0;
    localparam logic [7:0] TOP_FLAGS_RESET   = 8'h00;
    localparam logic [7:0] READ_DATA_RESET   = 8'h00;
    localparam logic [3:0] REG_ENABLE_RESET  = 4'h0;

endpackage : pmic_fault_pkg

// file: testbench/host_model.sv
// host side of the byte register port, one access at a time
module host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one-cycle write strobe; a flag is cleared by a one in its bit
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~addr; // released lines show no stale value
        reg_wdata = ~data;
    endtask : wr

    // one-cycle read strobe, answer taken once the taking edge has settled
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge sys_clk);
        #1;
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(posedge sys_clk);
        #1;
        ok       = reg_rvalid;
        data     = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~addr;
    endtask : rd
endmodule : host_model

// file: testbench/tb_pmic_fault_interrupt_regs.sv
module tb_pmic_fault_interrupt_regs;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk, rst_n, clk_en, reg_wr, reg_rd, reg_rvalid, fault_gating_select;
    logic       ext_clock_present, thermal_shutdown_live, thermal_warning_live;
    logic       input_overvoltage_live, current_result_ready, general_output_a_req;
    logic       general_output_b_req, power_ok_pin, general_output_a, general_output_b;
    logic       otp_reload, host_if_reset, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, linear_event_register, switcher_event_register;
    logic [3:0] output_valid, monitor_enable, regulator_enable_req, regulator_enable;
    int         errors, n_tests, cycles;

    pmic_fault_interrupt_regs u_pmic_fault_interrupt_regs (
        .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid, .output_valid, .monitor_enable, .fault_gating_select,
        .linear_event_register, .switcher_event_register, .ext_clock_present,
        .thermal_shutdown_live, .thermal_warning_live, .input_overvoltage_live,
        .current_result_ready, .regulator_enable_req, .general_output_a_req,
        .general_output_b_req, .power_ok_pin, .regulator_enable, .general_output_a,
        .general_output_b, .otp_reload, .host_if_reset, .irq
    );

    host_model u_host_model (
        .sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd
    );

    // 125 MHz clock
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // read a register, then compare both the answer pulse and the data
    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host_model.rd(addr, d, ok);
        check({what, " rvalid"}, {7'h00, ok}, 8'h01);
        check(what, d, exp);
    endtask : rd_chk

    // event source k sets top flag bit k; the clock source toggles once
    task automatic pulse(input int k);
        for (int v = 1; v >= 0; v--) begin
            @(posedge sys_clk);
            #1;
            case (k)
                0: current_result_ready = v[0];
                1: input_overvoltage_live = v[0];
                2: thermal_warning_live = v[0];
                3: thermal_shutdown_live = v[0];
                default: if (v == 1) ext_clock_present = ~ext_clock_present;
            endcase
        end
    endtask : pulse

    task automatic outs_chk(input logic [3:0] en, input logic gp);
        check("regulator_enable", {4'h0, regulator_enable}, {4'h0, en});
        check("general_outputs", {6'h00, general_output_a, general_output_b}, {6'h00, gp, gp});
    endtask : outs_chk

    initial begin
        {rst_n, fault_gating_select, ext_clock_present, thermal_shutdown_live} = 4'h0;
        {thermal_warning_live, input_overvoltage_live, current_result_ready} = 3'h0;
        {linear_event_register, switcher_event_register} = 16'h0000;
        {errors, n_tests, cycles} = '0;
        clk_en               = 1'b1;
        output_valid         = 4'hF;
        monitor_enable       = 4'hF;
        regulator_enable_req = 4'hF;
        general_output_a_req = 1'b1;
        general_output_b_req = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        // defaults after power-on reset
        rd_chk("fault_latch", 8'h17, 8'h00);
        rd_chk("top_flags", 8'h19, 8'h00);
        check("irq", {7'h00, irq}, 8'h00);
        outs_chk(4'hF, 1'b1);
        $display("test reset done");
        // latched events bits 0 to 4: set, hold on write 0, clear on write 1
        for (int k = 0; k < 5; k++) begin
            pulse(k);
            rd_chk("top_flags", 8'h19, 8'h01 << k);
            check("irq", {7'h00, irq}, 8'h01);
            if (k == 1 || k == 3) outs_chk(4'h0, 1'b0);
            u_host_model.wr(8'h19, 8'h00);
            rd_chk("top_flags", 8'h19, 8'h01 << k);
            u_host_model.wr(8'h19, 8'h01 << k);
            rd_chk("top_flags", 8'h19, 8'h00);
            check("irq", {7'h00, irq}, 8'h00);
            outs_chk(4'hF, 1'b1);
        end
        // live event during the clearing write keeps the flag
        current_result_ready = 1'b1;
        u_host_model.wr(8'h19, 8'h01);
        current_result_ready = 1'b0;
        rd_chk("top_flags", 8'h19, 8'h01);
        u_host_model.wr(8'h19, 8'h01);
        $display("test events done");
        // nothing moves while the clock enable is low
        clk_en = 1'b0;
        pulse(0);
        clk_en = 1'b1;
        rd_chk("frozen", 8'h19, 8'h00);
        check("irq", {7'h00, irq}, 8'h00);
        $display("test enable done");
        // summary flags follow the event registers and ignore writes
        linear_event_register = 8'h40;
        u_host_model.wr(8'h19, 8'h60);
        rd_chk("top_flags", 8'h19, 8'h40);
        switcher_event_register = 8'h02;
        linear_event_register   = 8'h00;
        rd_chk("top_flags", 8'h19, 8'h20);
        check("irq", {7'h00, irq}, 8'h01);
        switcher_event_register = 8'h00;
        rd_chk("top_flags", 8'h19, 8'h00);
        $display("test summaries done");
        // linear a drops while monitored, unmonitored switcher a drops too
        monitor_enable = 4'hE;
        output_valid   = 4'hA;
        @(posedge sys_clk);
        #1;
        output_valid = 4'hF;
        rd_chk("fault_latch", 8'h17, 8'h04);
        rd_chk("top_flags", 8'h19, 8'h80);
        check("power_ok_pin", {7'h00, power_ok_pin}, 8'h01);
        fault_gating_select = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check("power_ok_pin", {7'h00, power_ok_pin}, 8'h00);
        monitor_enable = 4'hA;
        output_valid   = 4'hB;
        u_host_model.wr(8'h17, 8'h04);
        rd_chk("fault_latch", 8'h17, 8'h04);
        output_valid = 4'hF;
        u_host_model.wr(8'h17, 8'h04);
        rd_chk("fault_latch", 8'h17, 8'h00);
        check("power_ok_pin", {7'h00, power_ok_pin}, 8'h01);
        $display("test fault latch done");
        // soft reset with flags and a fault pending
        monitor_enable = 4'hF;
        output_valid   = 4'hE;
        pulse(2);
        output_valid = 4'hF;
        u_host_model.wr(8'h18, 8'h01);
        check("reload_pulse", {6'h00, otp_reload, host_if_reset}, 8'h03);
        @(posedge sys_clk);
        #1;
        check("reload_pulse", {6'h00, otp_reload, host_if_reset}, 8'h00);
        rd_chk("fault_latch", 8'h17, 8'h00);
        rd_chk("top_flags", 8'h19, 8'h00);
        rd_chk("soft_reset", 8'h18, 8'h00);
        u_host_model.wr(8'h20, 8'hFF);
        rd_chk("unmapped", 8'h20, 8'h00);
        $display("test soft reset done");
        conclude();
    end
endmodule : tb_pmic_fault_interrupt_regs
